// ==== common/scan_pkg.sv ====
// package: constants, register map and state carriers of the current input scan block
package scan_pkg;

  // ==========================================================
  // clock and timebase
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ==========================================================
  // cycle timing in milliseconds
  localparam logic [7:0] BASE_MS = 8'd8;
  localparam logic [7:0] PAIR_MS_50HZ = 8'd23;
  localparam logic [7:0] PAIR_MS_60HZ = 8'd20;
  localparam logic [4:0] ACK_TIME_LIMIT_MS = 5'd25;
  localparam int NUM_CH = 8;
  localparam int NUM_PAIRS = 4;
  localparam int SMOOTH_FRAC = 6;
  localparam logic [2:0] SMOOTH_MAX = 3'd6;

  // ==========================================================
  // value coding
  localparam logic signed [15:0] CODE_NOMINAL_TOP = 16'sh6C00;
  localparam logic signed [15:0] CODE_OVERFLOW = 16'sh7F00;
  localparam logic signed [15:0] CODE_WB_0_20 = 16'sh0265;
  localparam logic signed [15:0] CODE_WB_4_20 = -16'sh02B4;
  localparam logic signed [15:0] CODE_UNDERRANGE_MIN = -16'sh1800;
  localparam logic signed [15:0] CODE_UNDERFLOW = -16'sh1801;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CHAN_EN = 8'h04;
  localparam logic [7:0] REG_DISC_TIME = 8'h08;
  localparam logic [7:0] REG_DISC_TOL = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam logic [7:0] REG_CYCLE_MS = 8'h18;
  localparam logic [7:0] REG_TYPICAL = 8'h1C;
  localparam logic [7:0] REG_WORST = 8'h20;
  localparam logic [7:0] REG_SINGLE_FAULT = 8'h24;
  localparam logic [7:0] REG_FAULT_CH = 8'h28;
  localparam logic [7:0] REG_DONE_CH = 8'h2C;
  localparam logic [2:0] REG_VALUE_BLOCK = 3'b010;
  localparam logic [2:0] REG_CLASS_BLOCK = 3'b011;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CHAN_EN_RESET = 8'hFF;
  localparam logic [15:0] DISC_TIME_RESET = 16'd100;
  localparam logic [15:0] DISC_TOL_RESET = 16'd276;

  // status bit positions
  localparam int ST_CYCLE = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_DISC = 2;
  localparam int ST_ACK = 3;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    CLS_NOMINAL, CLS_OVERRANGE, CLS_OVERFLOW, CLS_UNDERRANGE, CLS_UNDERFLOW, CLS_WIRE_BREAK
  } cls_e;

  typedef enum logic [1:0] {PH_IDLE, PH_BASE, PH_PAIR} phase_e;

  typedef struct packed {
    logic dual_channel_evaluation;
    logic wire_break_diag;
    logic range_4_20;
    logic [2:0] smooth;
    logic freq60;
    logic run;
  } ctrl_s;

  typedef struct packed {
    cls_e cls;
    logic [15:0] value;
  } coded_s;

  typedef struct packed {
    logic bus_ack;
    logic [31:0] rdata;
    ctrl_s ctrl;
    logic [7:0] chan_en;
    logic [15:0] disc_ms;
    logic [15:0] disc_tol;
    logic [3:0] status;
    logic [3:0] mask;
    logic [31:0] tick_cnt;
    logic tick;
    phase_e phase;
    logic [1:0] pair;
    logic [7:0] phase_ms;
    logic [3:0] act_pairs;
    logic [7:0] en_l;
    logic freq60_l;
    logic [2:0] smooth_l;
    logic [7:0] done_ch;
    logic [7:0][21:0] acc;
    logic [7:0][15:0] value;
    cls_e [7:0] cls;
    logic [7:0] fault_ch;
    logic [3:0] mism;
    logic [3:0][15:0] disc_cnt;
    logic msg_pend;
    logic [4:0] ack_ms;
    logic msg_ack;
  } state_s;

endpackage

// ==== hw/current_scan.sv ====
// current input scan scheduler, value coding and response bounds with Avalon-MM registers
module current_scan
  import scan_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // converter results, one signed word per channel
  input wire logic [7:0][15:0] adc_code,
  // safety message handshake
  input wire logic msg_req,
  output logic msg_ack,
  // events
  output logic cycle_done,
  output logic irq
);

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // helpers
  function automatic coded_s code_value(input logic signed [15:0] raw, input logic r420,
                                        input logic wb);
    coded_s c;
    c.value = raw;
    c.cls = CLS_NOMINAL;
    if (raw >= CODE_OVERFLOW) begin
      c.value = CODE_OVERFLOW;
      c.cls = CLS_OVERFLOW;
    end else if (raw > CODE_NOMINAL_TOP) begin
      c.cls = CLS_OVERRANGE;
    end else if (!r420) begin
      if (raw < 16'sh0000) begin
        c.value = 16'h0000;
      end
      if (raw <= CODE_WB_0_20) begin
        c.cls = CLS_WIRE_BREAK;
      end
    end else if (raw < 16'sh0000) begin
      if (wb && raw <= CODE_WB_4_20) begin
        c.cls = CLS_WIRE_BREAK;
      end else if (!wb && raw < CODE_UNDERRANGE_MIN) begin
        c.value = CODE_UNDERFLOW;
        c.cls = CLS_UNDERFLOW;
      end else begin
        c.cls = CLS_UNDERRANGE;
      end
    end
    return c;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // next active pair at or above start; bit 2 set when found
  function automatic logic [2:0] find_pair(input logic [3:0] act, input logic [2:0] start);
    logic [2:0] r;
    r = 3'b000;
    for (int p = NUM_PAIRS - 1; p >= 0; p--) begin
      if (act[p] && 3'(p) >= start) begin
        r = {1'b1, 2'(p)};
      end
    end
    return r;
  endfunction

  // ==========================================================
  // state and derived timing
  state_s s;
  state_s next_s;
  logic [3:0] cfg_pairs;
  logic [2:0] cnt_pairs;
  logic [7:0] pair_ms;
  logic [7:0] cycle_ms;
  logic [15:0] typical_ms;
  logic [15:0] worst_case_fault_free_delay;
  logic [31:0] single_fault_delay;
  logic bus_req;

  assign bus_req = read | write;
  assign cfg_pairs = s.chan_en[3:0] | s.chan_en[7:4];
  assign cnt_pairs = 3'(s.act_pairs[0]) + 3'(s.act_pairs[1]) + 3'(s.act_pairs[2])
                   + 3'(s.act_pairs[3]);
  assign pair_ms = s.freq60_l ? PAIR_MS_60HZ : PAIR_MS_50HZ;
  assign cycle_ms = BASE_MS + 8'(cnt_pairs) * pair_ms;
  assign typical_ms = 16'(cycle_ms) << s.smooth_l;
  assign worst_case_fault_free_delay = 16'(typical_ms << 1);
  assign single_fault_delay = s.ctrl.dual_channel_evaluation
    ? 32'(worst_case_fault_free_delay) + 32'(s.disc_ms) + 32'(cycle_ms) * 32'd2
    : 32'(cycle_ms) * 32'd2;

  // ==========================================================
  // next state
  always_comb begin
    logic [2:0] nxt;
    logic end_cycle;
    logic phase_end;
    logic [31:0] wr;
    logic signed [22:0] diff;
    logic signed [16:0] gap;
    coded_s cr;
    coded_s cf;
    int ch;
    int pa;
    nxt = 3'b000;
    end_cycle = 1'b0;
    phase_end = 1'b0;
    wr = 32'h0000_0000;
    diff = 23'sh000000;
    gap = 17'sh00000;
    cr = '0;
    cf = '0;
    ch = 0;
    pa = 0;
    next_s = s;
    next_s.msg_ack = 1'b0;

    // millisecond tick
    next_s.tick = 1'b0;
    if (s.tick_cnt == 32'(TICK_LEN - 1)) begin
      next_s.tick_cnt = 32'h0000_0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 32'h0000_0001;
    end

    // scan scheduler
    if (s.tick) begin
      unique case (s.phase)
        PH_IDLE: begin
          if (s.ctrl.run) begin
            next_s.phase = PH_BASE;
            next_s.phase_ms = 8'h00;
            next_s.act_pairs = cfg_pairs;
            next_s.en_l = s.chan_en;
            next_s.freq60_l = s.ctrl.freq60;
            next_s.smooth_l = (s.ctrl.smooth > SMOOTH_MAX) ? SMOOTH_MAX : s.ctrl.smooth;
            next_s.done_ch = 8'h00;
          end
        end
        PH_BASE: begin
          next_s.phase_ms = s.phase_ms + 8'h01;
          if (s.phase_ms == BASE_MS - 8'h01) begin
            phase_end = 1'b1;
            nxt = find_pair(s.act_pairs, 3'b000);
            if (nxt[2]) begin
              next_s.phase = PH_PAIR;
              next_s.pair = nxt[1:0];
              next_s.phase_ms = 8'h00;
            end else begin
              end_cycle = 1'b1;
            end
          end
        end
        PH_PAIR: begin
          next_s.phase_ms = s.phase_ms + 8'h01;
          if (s.phase_ms == pair_ms - 8'h01) begin
            phase_end = 1'b1;
            for (int h = 0; h < 2; h++) begin
              ch = int'(s.pair) + h * NUM_PAIRS;
              if (s.en_l[ch] && !s.done_ch[ch]) begin
                next_s.done_ch[ch] = 1'b1;
                cr = code_value(adc_code[ch], s.ctrl.range_4_20, s.ctrl.wire_break_diag);
                next_s.cls[ch] = cr.cls;
                next_s.fault_ch[ch] = (cr.cls == CLS_OVERFLOW) || (cr.cls == CLS_UNDERFLOW)
                                   || (cr.cls == CLS_WIRE_BREAK);
                if (next_s.fault_ch[ch] && !s.fault_ch[ch]) begin
                  next_s.status[ST_FAULT] = 1'b1;
                end
                diff = {adc_code[ch][15], adc_code[ch], 6'b000000}
                     - {s.acc[ch][21], s.acc[ch]};
                if (s.smooth_l == 3'b000) begin
                  next_s.acc[ch] = {adc_code[ch], 6'b000000};
                end else begin
                  next_s.acc[ch] = s.acc[ch] + 22'(diff >>> s.smooth_l);
                end
                cf = code_value(next_s.acc[ch][21:6], s.ctrl.range_4_20,
                                s.ctrl.wire_break_diag);
                next_s.value[ch] = cf.value;
              end
            end
            pa = int'(s.pair);
            if (s.ctrl.dual_channel_evaluation && s.en_l[pa] && s.en_l[pa + NUM_PAIRS]) begin
              gap = 17'($signed(next_s.value[pa])) - 17'($signed(next_s.value[pa + NUM_PAIRS]));
              if (gap < 17'sh00000) begin
                gap = -gap;
              end
              next_s.mism[pa] = gap > $signed({1'b0, s.disc_tol});
            end else begin
              next_s.mism[pa] = 1'b0;
            end
            nxt = find_pair(s.act_pairs, 3'(s.pair) + 3'b001);
            if (nxt[2]) begin
              next_s.pair = nxt[1:0];
              next_s.phase_ms = 8'h00;
            end else begin
              end_cycle = 1'b1;
            end
          end
        end
        default: next_s.phase = PH_IDLE;
      endcase
    end

    // cycle end: relatch configuration for the next cycle
    if (end_cycle) begin
      next_s.status[ST_CYCLE] = 1'b1;
      next_s.done_ch = 8'h00;
      next_s.phase_ms = 8'h00;
      next_s.act_pairs = cfg_pairs;
      next_s.en_l = s.chan_en;
      next_s.freq60_l = s.ctrl.freq60;
      next_s.smooth_l = (s.ctrl.smooth > SMOOTH_MAX) ? SMOOTH_MAX : s.ctrl.smooth;
      next_s.phase = s.ctrl.run ? PH_BASE : PH_IDLE;
    end

    // discrepancy timers
    for (int p = 0; p < NUM_PAIRS; p++) begin
      if (!s.mism[p]) begin
        next_s.disc_cnt[p] = 16'h0000;
      end else if (s.tick && s.disc_cnt[p] != 16'hFFFF) begin
        next_s.disc_cnt[p] = s.disc_cnt[p] + 16'h0001;
        if (s.disc_cnt[p] == s.disc_ms) begin
          next_s.status[ST_DISC] = 1'b1;
        end
      end
    end

    // safety message acknowledge at the next phase boundary, at once while idle, or 2 ms before the limit
    if (msg_req) begin
      next_s.msg_pend = 1'b1;
    end
    if (s.msg_pend) begin
      if (s.tick) begin
        next_s.ack_ms = s.ack_ms + 5'd1;
      end
      if (phase_end || s.phase == PH_IDLE || s.ack_ms >= ACK_TIME_LIMIT_MS - 5'd2) begin
        next_s.msg_ack = 1'b1;
        next_s.msg_pend = msg_req;
        next_s.ack_ms = 5'd0;
        next_s.status[ST_ACK] = 1'b1;
      end
    end

    // register bus, answer on second cycle of each request
    next_s.bus_ack = bus_req & ~s.bus_ack;
    if (bus_req && !s.bus_ack && read) begin
      next_s.rdata = 32'h0000_0000;
      if (address[7:5] == REG_VALUE_BLOCK) begin
        next_s.rdata = {16'h0000, s.value[address[4:2]]};
      end else if (address[7:5] == REG_CLASS_BLOCK) begin
        next_s.rdata = {29'h0, s.cls[address[4:2]]};
      end else begin
        unique case (address)
          REG_CTRL: next_s.rdata = {24'h0, s.ctrl};
          REG_CHAN_EN: next_s.rdata = {24'h0, s.chan_en};
          REG_DISC_TIME: next_s.rdata = {16'h0, s.disc_ms};
          REG_DISC_TOL: next_s.rdata = {16'h0, s.disc_tol};
          REG_STATUS: next_s.rdata = {28'h0, s.status};
          REG_MASK: next_s.rdata = {28'h0, s.mask};
          REG_CYCLE_MS: next_s.rdata = {24'h0, cycle_ms};
          REG_TYPICAL: next_s.rdata = {16'h0, typical_ms};
          REG_WORST: next_s.rdata = {16'h0, worst_case_fault_free_delay};
          REG_SINGLE_FAULT: next_s.rdata = single_fault_delay;
          REG_FAULT_CH: next_s.rdata = {24'h0, s.fault_ch};
          REG_DONE_CH: next_s.rdata = {24'h0, s.done_ch};
          default: next_s.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (write && s.bus_ack) begin
      unique case (address)
        REG_CTRL: begin
          wr = merge({24'h0, s.ctrl}, writedata, byteenable);
          next_s.ctrl = wr[7:0];
        end
        REG_CHAN_EN: begin
          wr = merge({24'h0, s.chan_en}, writedata, byteenable);
          next_s.chan_en = wr[7:0];
        end
        REG_DISC_TIME: begin
          wr = merge({16'h0, s.disc_ms}, writedata, byteenable);
          next_s.disc_ms = wr[15:0];
        end
        REG_DISC_TOL: begin
          wr = merge({16'h0, s.disc_tol}, writedata, byteenable);
          next_s.disc_tol = wr[15:0];
        end
        REG_STATUS: begin
          // event set in this cycle wins over the clear
          if (byteenable[0]) begin
            next_s.status = next_s.status & ~(writedata[3:0] & ~(next_s.status & ~s.status));
          end
        end
        REG_MASK: begin
          wr = merge({28'h0, s.mask}, writedata, byteenable);
          next_s.mask = wr[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.chan_en <= CHAN_EN_RESET;
      s.disc_ms <= DISC_TIME_RESET;
      s.disc_tol <= DISC_TOL_RESET;
      s.phase <= PH_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign readdata = s.rdata;
  assign waitrequest = bus_req & ~s.bus_ack;
  assign msg_ack = s.msg_ack;
  assign cycle_done = s.status[ST_CYCLE];
  assign irq = |(s.status & s.mask);

endmodule // current_scan

// ==== verif/current_scan_checker.sv ====
// checker: concurrent properties on the ports of the current scan block
module current_scan_checker
  import scan_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // converter, message and events
  input wire logic [7:0][15:0] adc_code,
  input wire logic msg_req,
  input wire logic msg_ack,
  input wire logic cycle_done,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // helper state
  logic pend;
  logic clr_q;
  int unsigned age;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend <= 1'b0;
      clr_q <= 1'b0;
      age <= 0;
    end else begin
      pend <= (pend | msg_req) & ~msg_ack;
      age <= (pend & ~msg_ack) ? age + 1 : 0;
      clr_q <= write & ~waitrequest & (address == REG_STATUS) & writedata[0] & byteenable[0];
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  sequence read_answer;
    read && !waitrequest;
  endsequence
  a_bus_one_wait: assert property ($rose(read | write) |-> one_wait)
    else $error("bus answer not after one wait cycle");
  a_ack_bound: assert property (age < int'(ACK_TIME_LIMIT_MS) * TICK_LEN)
    else $error("message not answered in time");
  a_ack_pulse: assert property (msg_ack |=> !msg_ack)
    else $error("message answer longer than one cycle");
  a_ack_cause: assert property (msg_ack |-> pend)
    else $error("message answer without request");
  a_done_sticky: assert property ($fell(cycle_done) |-> clr_q)
    else $error("cycle end flag dropped without clear");
  a_read_hold: assert property ($changed(readdata) |-> read_answer)
    else $error("read data changed outside an answer");
  a_value_width: assert property (read_answer and address[7:5] == REG_VALUE_BLOCK
      |-> readdata[31:16] == 16'h0000)
    else $error("value word wider than 16 bits");
  a_class_code: assert property (read_answer and address[7:5] == REG_CLASS_BLOCK
      |-> readdata <= 32'h5)
    else $error("class code out of range");
  a_unmapped_zero: assert property (read_answer and address == 8'hFC |-> readdata == 0)
    else $error("unmapped read not zero");
endmodule // current_scan_checker

bind current_scan current_scan_checker #(.TICK_LEN(TICK_LEN)) u_current_scan_checker (
  .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .adc_code(adc_code), .msg_req(msg_req),
  .msg_ack(msg_ack), .cycle_done(cycle_done), .irq(irq)
);

// ==== verif/field_side_model.sv ====
// partner model: converter feed and safety message requester
module field_side_model
  import scan_pkg::*;
(
  // clock
  input wire logic clk,
  // scenario control
  input wire logic [1:0] mode,
  input wire logic send,
  // toward the scan block
  output logic [7:0][15:0] adc_code,
  output logic msg_req,
  input wire logic msg_ack,
  // answer time in cycles
  output int unsigned ack_wait
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // converter words per test mode, channel 0 first
  localparam logic [15:0] CODES [4][8] = '{
    '{16'h6C00, 16'h7EFF, 16'h7F00, 16'h0265, 16'h0266, 16'h0000, 16'hFFFB, 16'h03E8},
    '{16'h0000, 16'hFFFF, 16'hFD4D, 16'hFD4C, 16'h6C01, 16'h7F00, 16'h6C00, 16'h0001},
    '{16'hE800, 16'hE7FF, 16'hFD4C, 16'h0000, 16'h6C00, 16'h7EFF, 16'hFFFF, 16'h7F00},
    '{default: 16'h0000}
  };
  logic counting = 1'b0;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      adc_code[i] = CODES[mode][i];
    end
  end

  // ==========================================================
  // one-cycle request, then count cycles until the answer
  always @(posedge clk) begin
    msg_req <= send;
    if (send) begin
      counting <= 1'b1;
      ack_wait <= 0;
    end else if (counting && msg_ack) begin
      counting <= 1'b0;
    end else if (counting) begin
      ack_wait <= ack_wait + 1;
    end
  end
endmodule // field_side_model

// ==== verif/testbench.sv ====
// testbench: bus-level tests of the current scan block
module testbench
  import scan_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TL = 10;
  localparam logic [7:0] EN [4] = '{8'h33, 8'h17, 8'h10, 8'hFF};
  localparam logic [7:0] CT [4] = '{8'h89, 8'h03, 8'h99, 8'h1F};
  localparam logic [7:0] CM [3] = '{8'h01, 8'h61, 8'h21};
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest, msg_req, msg_ack, cycle_done, irq;
  logic [7:0][15:0] adc_code;
  logic [1:0] mode = 2'h0;
  logic send = 1'b0;
  logic done_q = 1'b0;
  int unsigned ack_wait;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int t_rise = 0;

  always #20 clk = ~clk;

  current_scan #(.TICK_LEN(TL)) u_current_scan (
    .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .adc_code(adc_code), .msg_req(msg_req),
    .msg_ack(msg_ack), .cycle_done(cycle_done), .irq(irq)
  );
  field_side_model u_field_side_model (
    .clk(clk), .mode(mode), .send(send), .adc_code(adc_code), .msg_req(msg_req),
    .msg_ack(msg_ack), .ack_wait(ack_wait)
  );

  // ==========================================================
  // tasks
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0 && ++n < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) errors++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(name, q, exp);
  endtask

  task automatic wait_end();
    int n;
    n = 0;
    do @(negedge clk); while (cycle_done !== 1'b1 && ++n < 3000);
    if (n >= 3000) errors++;
  endtask

  task automatic next_end();
    wait_end();
    wr(REG_STATUS, 32'h1);
  endtask

  task automatic msg_test();
    logic [31:0] q;
    int n;
    n = 0;
    @(posedge clk);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    do @(negedge clk); while (msg_ack !== 1'b1 && ++n < 2000);
    if (n >= 2000) errors++;
    bus(1'b0, REG_STATUS, 32'h0, q);
    check("ack flag", {31'h0, q[ST_ACK]}, 32'h1);
    check("ack time", {31'h0, ack_wait <= 25 * TL}, 32'h1);
    wr(REG_STATUS, 32'h8);
  endtask

  function automatic logic [2:0] cls_of(input int m, input logic signed [15:0] c);
    if (c >= 16'sh7F00) return CLS_OVERFLOW;
    if (c > 16'sh6C00) return CLS_OVERRANGE;
    if (m == 0) return (c <= 16'sh0265) ? CLS_WIRE_BREAK : CLS_NOMINAL;
    if (c >= 16'sh0000) return CLS_NOMINAL;
    if (m == 1 && c <= -16'sh02B4) return CLS_WIRE_BREAK;
    if (m == 2 && c <= -16'sh1801) return CLS_UNDERFLOW;
    return CLS_UNDERRANGE;
  endfunction

  // ==========================================================
  // timeout and cycle end timestamps
  always @(posedge clk) begin
    cyc <= cyc + 1;
    done_q <= cycle_done;
    if (cycle_done === 1'b1 && done_q !== 1'b1) t_rise <= cyc;
    if (cyc == 60000) begin
      errors++;
      report_and_stop();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] q;
    logic signed [15:0] c;
    logic [7:0] f;
    int n, cm, s, k;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk("ctrl", REG_CTRL, 32'(CTRL_RESET));
    rd_chk("chan_en", REG_CHAN_EN, 32'(CHAN_EN_RESET));
    rd_chk("disc time", REG_DISC_TIME, 32'(DISC_TIME_RESET));
    rd_chk("disc tol", REG_DISC_TOL, 32'(DISC_TOL_RESET));
    rd_chk("status", REG_STATUS, 32'h0);
    wr(8'hFC, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'hFC, 32'h0);
    msg_test();
    for (int i = 0; i < 4; i++) begin
      wr(REG_CHAN_EN, 32'(EN[i]));
      wr(REG_CTRL, 32'(CT[i]));
      next_end();
      next_end();
      n = 0;
      for (int p = 0; p < 4; p++) n += int'(EN[i][p] | EN[i][p + 4]);
      cm = int'(BASE_MS) + n * int'(CT[i][1] ? PAIR_MS_60HZ : PAIR_MS_50HZ);
      k = (CT[i][4:2] > 3'd6) ? 6 : int'(CT[i][4:2]);
      s = 1 << k;
      q = t_rise;
      next_end();
      check("period", t_rise - q, cm * TL);
      wr(REG_CYCLE_MS, 32'h0FFF);
      rd_chk("cycle ms", REG_CYCLE_MS, cm);
      rd_chk("typical", REG_TYPICAL, cm * s);
      rd_chk("worst", REG_WORST, 2 * cm * s);
      rd_chk("single fault", REG_SINGLE_FAULT,
             CT[i][7] ? 2 * cm * s + int'(DISC_TIME_RESET) + 2 * cm : 2 * cm);
      if (i == 1) msg_test();
    end
    wr(REG_MASK, 32'h1);
    rd_chk("mask", REG_MASK, 32'h1);
    wait_end();
    check("irq set", {31'h0, irq}, 32'h1);
    wr(REG_STATUS, 32'h1);
    @(negedge clk);
    check("irq clear", {31'h0, irq}, 32'h0);
    wait_end();
    wr(REG_MASK, 32'h0);
    @(negedge clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    check("done sticky", {31'h0, cycle_done}, 32'h1);
    wr(REG_STATUS, 32'hF);
    for (int m = 0; m < 3; m++) begin
      mode <= 2'(m);
      wr(REG_CTRL, 32'(CM[m]));
      next_end();
      next_end();
      f = 8'h00;
      for (int ch = 0; ch < 8; ch++) begin
        c = adc_code[ch];
        f[ch] = cls_of(m, c) inside {CLS_OVERFLOW, CLS_UNDERFLOW, CLS_WIRE_BREAK};
        rd_chk("value", 8'h40 + 8'(4 * ch), {16'h0, (m == 0 && c < 0) ? 16'h0 : c});
        rd_chk("class", 8'h60 + 8'(4 * ch), {29'h0, cls_of(m, c)});
      end
      rd_chk("fault ch", REG_FAULT_CH, 32'(f));
    end
    report_and_stop();
  end
endmodule // testbench
